// File: otpp_defines.svh
// Constants of the programming port: sizes, reset values, mode width.
// Assumes inclusion by bare name from every design file that needs them.
// Functional notes
// - Eight-bit data bus carries bytes both ways: reads out, writes in.
// - Direction input low drives bus out; high keeps bus as input.
// - Array select low is required for read, program and verify.
// - Clear input high holds address counter at its reset value.
// - Each address clock cycle advances the counter by exactly one.
// - Write strobe low commits bus byte at current counter address.
// - Programmed disable option refuses programming and test mode entry.
// - Counter reaches every byte of a one or two kilobyte memory.
`ifndef OTPP_DEFINES_SVH
`define OTPP_DEFINES_SVH
`define OTPP_MEM_BYTES     2048
`define OTPP_DATA_W        8
`define OTPP_FIFO_DEPTH    16
`define OTPP_ADDR_RESET    11'h000
`define OTPP_BLANK_BYTE    8'hFF
`define OTPP_MODE_W        2
`endif

// File: otpp_pkg.sv
// Types shared by the programming port, its checker, the programmer model and the bench.
// Assumes nothing beyond a SystemVerilog elaborator.
package otpp_pkg;
  // Decoded levels of the mode select pin, made by the pad decoder outside
  typedef enum logic [1:0] {
    OTPP_MODE_IDLE,
    OTPP_MODE_READ,
    OTPP_MODE_PROGRAM,
    OTPP_MODE_VERIFY
  } otpp_mode_e;
  // Write path states
  typedef enum logic [1:0] {
    OTPP_WR_IDLE,
    OTPP_WR_PUSHED,
    OTPP_WR_WAIT_HIGH
  } otpp_wr_e;
endpackage : otpp_pkg

// File: otpp_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
module otpp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  wire              doPush;
  wire              doPop;

  // Honest full and empty from the occupancy count
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;
  assign outData  = mem[rdPtr_q];

  // Pointer wrap written out so non power-of-two depths still work
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == (AW)'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // Storage array carries no reset
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) wrPtr_q <= bump(wrPtr_q);
      if (doPop) rdPtr_q <= bump(rdPtr_q);
      count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule : otpp_fifo

// File: otpp_port.sv
// Programming-mode port of the one-time-programmable program memory.
// Assumes pins already synchronous to clk_sys and the mode pin decoded
// outside into otpp_pkg::otpp_mode_e; the data pads resolve the bus wire.
`include "otpp_defines.svh"
module otpp_port #(
  parameter int MEM_BYTES = `OTPP_MEM_BYTES,
  parameter int DEPTH     = `OTPP_FIFO_DEPTH
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     arraySelect_n,
  input  wire logic                     outputDir_n,
  input  wire logic                     write_strobe_n,
  input  wire logic                     counterClear,
  input  wire logic                     addressClock,
  input  wire otpp_pkg::otpp_mode_e     prog_mode_select,
  input  wire logic                     disableOption,
  input  wire logic [`OTPP_DATA_W-1:0]  prog_data_bus_in,
  output logic      [`OTPP_DATA_W-1:0]  prog_data_bus_out,
  output logic                          prog_data_bus_oe,
  output logic      [$clog2(MEM_BYTES)-1:0] progAddress,
  output logic                          progModeActive,
  output logic                          writeBusy
);
  localparam int AW = $clog2(MEM_BYTES);
  localparam int DW = `OTPP_DATA_W;

  // Transfer walk, edge by edge, as the programmer drives it:
  //   program  edge 0: mode, select low, byte and strobe low sampled;
  //                    byte and counter pushed together
  //            edge 1: head leaves the FIFO and lands in the array
  //            edge 2+: sequencer waits for the strobe to rise again
  //   read     edge 0: select, mode and direction sampled
  //            edge 1: byte and bus enable stand on the pins
  //   address  each sampled rising level of the address clock steps once
  //   refused  select high, mode idle or disable set: no take, bus input
  // Limitation: pins are taken as synchronous; slow pads need outside
  // synchronisers, or the edge detector may count a glitch as a step.

  logic [DW-1:0] otpArray [MEM_BYTES];

  // Counter, edge history and registered bus outputs
  logic [AW-1:0]        addr_q;
  logic                 clkPrev_q;
  logic [DW-1:0]        rdData_q;
  logic                 dirOut_q;

  // Write sequencer and the address queue kept beside the data FIFO
  otpp_pkg::otpp_wr_e   wrState_q;
  otpp_pkg::otpp_wr_e   wrState_d;
  logic [AW-1:0]        wrAddr_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] tagWr_q;
  logic [$clog2(DEPTH)-1:0] tagRd_q;

  // Mode decode
  wire            modeAllowed;
  wire            selected;
  wire            isRead;
  wire            isProgram;
  wire            isVerify;
  wire            readReq;
  wire            driveReq;
  wire            writeReq;

  // Counter control
  wire            clkRise;
  wire            addrClear;

  // FIFO handshakes
  wire            pushValid;
  wire            pushReady;
  wire            pushTake;
  wire [DW-1:0]   popData;
  wire            popValid;
  wire            popReady;
  wire            popTake;
  wire [AW-1:0]   popAddr;

  // Read source selection
  wire            bypassHit;
  wire [DW-1:0]   readByte;

  // Equality against one decoded mode, shared by every decode below
  function automatic logic modeIs(input otpp_pkg::otpp_mode_e cur, input otpp_pkg::otpp_mode_e want);
    modeIs = (cur == want);
  endfunction : modeIs

  // Slot pointer wrap, written out so a depth that is no power of two works
  function automatic logic [$clog2(DEPTH)-1:0] tagBump(input logic [$clog2(DEPTH)-1:0] p);
    tagBump = (p == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : tagBump

  // Disable option blocks every mode entry
  assign modeAllowed = ~disableOption & ~modeIs(prog_mode_select, otpp_pkg::OTPP_MODE_IDLE);
  assign selected    = modeAllowed & ~arraySelect_n;
  assign isRead      = selected & modeIs(prog_mode_select, otpp_pkg::OTPP_MODE_READ);
  assign isProgram   = selected & modeIs(prog_mode_select, otpp_pkg::OTPP_MODE_PROGRAM);
  assign isVerify    = selected & modeIs(prog_mode_select, otpp_pkg::OTPP_MODE_VERIFY);

  // Read and verify share one bus answer; direction low asks for drive
  assign readReq     = isRead | isVerify;
  assign driveReq    = readReq & ~outputDir_n;
  // A byte is offered only while the strobe stays low
  assign writeReq    = isProgram & ~write_strobe_n;

  // Sampled rising level of the address clock; clear overrides it
  assign clkRise     = addressClock & ~clkPrev_q;
  assign addrClear   = ~reset_n | counterClear;

  // Address clock edge detector; pins are already synchronous
  // Resets low, the idle level of the pin, so no false step follows reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) clkPrev_q <= 1'b0;
    else clkPrev_q <= addressClock;
  end

  // Clear holds counter; one step per clock; zero start
  // Clear wins over a coincident clock edge, so no step leaks past it
  always_ff @(posedge clk_sys) begin
    if (addrClear) begin
      addr_q <= AW'(`OTPP_ADDR_RESET);
    end else if (clkRise) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  // Write strobe pushes byte and address once per low phase
  always_comb begin
    wrState_d = wrState_q;
    case (wrState_q)
      // Waiting for a low strobe with room in the FIFO
      otpp_pkg::OTPP_WR_IDLE: begin
        if (writeReq && pushReady) wrState_d = otpp_pkg::OTPP_WR_PUSHED;
      end
      // Byte taken; one edge before watching the strobe again
      otpp_pkg::OTPP_WR_PUSHED: begin
        wrState_d = otpp_pkg::OTPP_WR_WAIT_HIGH;
      end
      // A strobe held low writes once, never twice
      otpp_pkg::OTPP_WR_WAIT_HIGH: begin
        if (write_strobe_n) wrState_d = otpp_pkg::OTPP_WR_IDLE;
      end
      default: wrState_d = otpp_pkg::OTPP_WR_IDLE;
    endcase
  end

  // Sequencer register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) wrState_q <= otpp_pkg::OTPP_WR_IDLE;
    else wrState_q <= wrState_d;
  end

  // A full FIFO stalls the push until the array drains a slot
  assign pushValid = (wrState_q == otpp_pkg::OTPP_WR_IDLE) & writeReq;
  assign pushTake  = pushValid & pushReady;
  // Array write port is always free, so the drain never stalls
  assign popReady  = 1'b1;
  assign popTake   = popValid & popReady;
  assign popAddr   = wrAddr_q[tagRd_q];
  assign writeBusy = popValid | ~pushReady;

  // Byte buffer between the strobe and the array write port
  otpp_fifo #(
    .WIDTH (DW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .inData   (prog_data_bus_in),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .outData  (popData),
    .outValid (popValid),
    .outReady (popReady)
  );

  // Address side queue kept in step with the data FIFO
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tagWr_q <= '0;
      tagRd_q <= '0;
    end else begin
      if (pushTake) tagWr_q <= tagBump(tagWr_q);
      if (popTake) tagRd_q <= tagBump(tagRd_q);
    end
  end

  // Counter captured with the byte, so a later step cannot move the write
  always_ff @(posedge clk_sys) begin
    if (pushTake) wrAddr_q[tagWr_q] <= addr_q;
  end

  // Commit into the array; no reset so it maps onto memory
  // An unprogrammed location therefore reads back as unknown
  always_ff @(posedge clk_sys) begin
    if (popTake) otpArray[popAddr] <= popData;
  end

  // Head of the FIFO beats the array, so a verify right after program sees
  // the new byte; only the head is checked, as the drain runs every cycle
  assign bypassHit = popValid & (popAddr == addr_q);
  assign readByte  = bypassHit ? popData : otpArray[addr_q];

  // Read and verify return the addressed byte
  always_ff @(posedge clk_sys) begin
    if (!reset_n) rdData_q <= `OTPP_BLANK_BYTE;
    else if (readReq) rdData_q <= readByte;
  end

  // Direction pin low drives the bus, high keeps it input
  always_ff @(posedge clk_sys) begin
    if (!reset_n) dirOut_q <= 1'b0;
    else dirOut_q <= driveReq;
  end

  // Pin-facing outputs straight from registers, mode flag from decode
  assign prog_data_bus_out = rdData_q;
  assign prog_data_bus_oe  = dirOut_q;
  assign progAddress       = addr_q;
  assign progModeActive    = modeAllowed;
endmodule : otpp_port

// File: otpp_port_assertions.sv
// Checker of the programming port pins, bound to every otpp_port.
// Assumes one clock domain with a synchronous active-low reset.
`include "otpp_defines.svh"
module otpp_port_assertions #(
  parameter int MEM_BYTES = `OTPP_MEM_BYTES
) (
  input wire logic                         clk_sys,
  input wire logic                         reset_n,
  input wire logic                         arraySelect_n,
  input wire logic                         outputDir_n,
  input wire logic                         write_strobe_n,
  input wire logic                         counterClear,
  input wire logic                         addressClock,
  input wire otpp_pkg::otpp_mode_e         prog_mode_select,
  input wire logic                         disableOption,
  input wire logic                         prog_data_bus_oe,
  input wire logic [$clog2(MEM_BYTES)-1:0] progAddress,
  input wire logic                         progModeActive,
  input wire logic                         writeBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Request shapes as the programmer presents them
  sequence s_clk_rise;
    $rose(addressClock) && !counterClear;
  endsequence
  sequence s_read_req;
    !outputDir_n && !arraySelect_n && !disableOption &&
    prog_mode_select inside {otpp_pkg::OTPP_MODE_READ, otpp_pkg::OTPP_MODE_VERIFY};
  endsequence
  sequence s_write_take;
    $fell(write_strobe_n) && !arraySelect_n && !disableOption && !writeBusy &&
    prog_mode_select == otpp_pkg::OTPP_MODE_PROGRAM;
  endsequence
  a_clear_zero: assert property (counterClear |=> progAddress == '0)
    else $error("address not zero after clear");
  a_clock_step: assert property (s_clk_rise |=> progAddress == $past(progAddress) + 1'b1)
    else $error("address did not step by one");
  a_hold_addr: assert property (!$rose(addressClock) && !counterClear |=> $stable(progAddress))
    else $error("address moved without a clock");
  a_write_busy: assert property (s_write_take |=> writeBusy)
    else $error("write not taken");
  a_read_answer: assert property (s_read_req |=> prog_data_bus_oe)
    else $error("read not answered");
  a_bus_off: assert property (outputDir_n || arraySelect_n || disableOption |=> !prog_data_bus_oe)
    else $error("bus driven while refused");
  a_oe_cause: assert property (prog_data_bus_oe |-> !$past(outputDir_n) && !$past(arraySelect_n))
    else $error("bus driven without request");
  a_mode_gate: assert property (progModeActive == (prog_mode_select != otpp_pkg::OTPP_MODE_IDLE && !disableOption))
    else $error("mode active flag wrong");
endmodule : otpp_port_assertions
bind otpp_port otpp_port_assertions #(.MEM_BYTES(MEM_BYTES)) u_chk (
  .clk_sys          (clk_sys),
  .reset_n          (reset_n),
  .arraySelect_n    (arraySelect_n),
  .outputDir_n      (outputDir_n),
  .write_strobe_n   (write_strobe_n),
  .counterClear     (counterClear),
  .addressClock     (addressClock),
  .prog_mode_select (prog_mode_select),
  .disableOption    (disableOption),
  .prog_data_bus_oe (prog_data_bus_oe),
  .progAddress      (progAddress),
  .progModeActive   (progModeActive),
  .writeBusy        (writeBusy)
);

// File: otpp_programmer.sv
// Behavioural device programmer driving the programming pins.
// Assumes its tasks are called one at a time, from one process.
module otpp_programmer (
  input  wire logic           clk_sys,
  input  wire logic [7:0]     prog_data_bus_out,
  input  wire logic           prog_data_bus_oe,
  output logic                arraySelect_n,
  output logic                outputDir_n,
  output logic                write_strobe_n,
  output logic                counterClear,
  output logic                addressClock,
  output otpp_pkg::otpp_mode_e prog_mode_select,
  output logic [7:0]          prog_data_bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drvData;
  logic [7:0] idleV = 8'hA5;
  logic       drvOn;
  // Released bus shows a changing pattern, so no stale byte can pass
  always @(posedge clk_sys) idleV <= ~idleV;
  // wire level resolved from both drivers
  assign prog_data_bus_in = prog_data_bus_oe ? prog_data_bus_out : (drvOn ? drvData : idleV);
  // Idle pins at time zero
  initial begin
    {arraySelect_n, outputDir_n, write_strobe_n} = 3'h7;
    {counterClear, addressClock, drvOn} = 3'h0;
    prog_mode_select = otpp_pkg::OTPP_MODE_IDLE;
    drvData = 8'h00;
  end
  // byte held on the bus while strobe is low
  task automatic wr(input logic [7:0] d, input logic sel);
    @(negedge clk_sys);
    prog_mode_select = otpp_pkg::OTPP_MODE_PROGRAM;
    {arraySelect_n, drvOn, drvData, write_strobe_n} = {sel, 1'b1, d, 1'b0};
    repeat (2) @(negedge clk_sys);
    write_strobe_n = 1'b1;
    @(negedge clk_sys);
    {arraySelect_n, drvOn} = 2'h2;
  endtask : wr
  // one cycle of device drive requested
  task automatic rd(input otpp_pkg::otpp_mode_e m, input logic sel);
    @(negedge clk_sys);
    prog_mode_select = m;
    {arraySelect_n, outputDir_n} = {sel, 1'b0};
    @(negedge clk_sys);
    {arraySelect_n, outputDir_n} = 2'h3;
  endtask : rd
  // one high cycle, then low again
  task automatic tick(input logic clr);
    @(negedge clk_sys);
    {counterClear, addressClock} = {clr, ~clr};
    @(negedge clk_sys);
    {counterClear, addressClock} = 2'h0;
  endtask : tick
endmodule : otpp_programmer

// File: otpp_port_tb.sv
// Self-checking bench of the programming port with a programmer model.
// Assumes design, checker and programmer model are compiled first.
module otpp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, disableOption, arraySelect_n, outputDir_n, write_strobe_n;
  logic counterClear, addressClock, prog_data_bus_oe, progModeActive, writeBusy;
  logic [7:0]  prog_data_bus_in, prog_data_bus_out, d [8];
  logic [7:0]  expQ [$];
  logic [10:0] progAddress;
  otpp_pkg::otpp_mode_e prog_mode_select;
  int          error_cnt, cmp_count, seed;
  otpp_port u_dut (
    .clk_sys           (clk_sys),
    .reset_n           (reset_n),
    .arraySelect_n     (arraySelect_n),
    .outputDir_n       (outputDir_n),
    .write_strobe_n    (write_strobe_n),
    .counterClear      (counterClear),
    .addressClock      (addressClock),
    .prog_mode_select  (prog_mode_select),
    .disableOption     (disableOption),
    .prog_data_bus_in  (prog_data_bus_in),
    .prog_data_bus_out (prog_data_bus_out),
    .prog_data_bus_oe  (prog_data_bus_oe),
    .progAddress       (progAddress),
    .progModeActive    (progModeActive),
    .writeBusy         (writeBusy)
  );
  otpp_programmer u_prog (
    .clk_sys           (clk_sys),
    .prog_data_bus_out (prog_data_bus_out),
    .prog_data_bus_oe  (prog_data_bus_oe),
    .arraySelect_n     (arraySelect_n),
    .outputDir_n       (outputDir_n),
    .write_strobe_n    (write_strobe_n),
    .counterClear      (counterClear),
    .addressClock      (addressClock),
    .prog_mode_select  (prog_mode_select),
    .prog_data_bus_in  (prog_data_bus_in)
  );
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Every driven bus cycle takes the oldest noted byte; none noted never matches
  always @(negedge clk_sys) begin
    if (prog_data_bus_oe === 1'b1)
      check(prog_data_bus_out, expQ.size() > 0 ? {3'h0, expQ.pop_front()} : 11'h400);
  end
  // Hang guard, well beyond the expected run
  initial begin
    #(40 * 10000);
    error_cnt++;
    wrap_up();
  end
  initial begin
    {reset_n, disableOption} = 2'h0;
    seed = 32'h4B2E;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    check(prog_data_bus_oe, 0);
    check(progAddress, 0);
    // Program random bytes at consecutive locations
    u_prog.tick(1);
    for (int i = 0; i < 8; i++) begin
      d[i] = $random(seed);
      u_prog.wr(d[i], 1'b0);
      u_prog.tick(0);
    end
    check(progAddress, 11'h008);
    // Refused writes and reads over location zero: disabled, then deselected
    u_prog.tick(1);
    for (int k = 0; k < 2; k++) begin
      disableOption = (k == 0);
      u_prog.wr(~d[0], k[0]);
      check(progModeActive, k[0]);
      u_prog.rd(otpp_pkg::OTPP_MODE_READ, k[0]);
    end
    disableOption = 1'b0;
    // Read back in both read modes, then idle mode gives no answer
    for (int i = 0; i < 8; i++) begin
      expQ.push_back(d[i]);
      u_prog.rd(i[0] ? otpp_pkg::OTPP_MODE_VERIFY : otpp_pkg::OTPP_MODE_READ, 1'b0);
      u_prog.tick(0);
    end
    u_prog.rd(otpp_pkg::OTPP_MODE_IDLE, 1'b0);
    // Top byte of the largest memory
    u_prog.tick(1);
    repeat (2047) u_prog.tick(0);
    check(progAddress, 11'h7FF);
    d[0] = $random(seed);
    u_prog.wr(d[0], 1'b0);
    expQ.push_back(d[0]);
    u_prog.rd(otpp_pkg::OTPP_MODE_VERIFY, 1'b0);
    repeat (2) @(negedge clk_sys);
    check(expQ.size(), 0);
    // Mid-run reset from the top address clears counter and bus drive
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    check(progAddress, 11'h000);
    check(prog_data_bus_oe, 11'h000);
    check(writeBusy, 11'h000);
    wrap_up();
  end
endmodule : otpp_port_tb
